// ===== core/can_buffer_id_mask_select.sv
// Avalon-MM register slice: buffer extended ids, upper mask select and bit timing control
//
// Behaviour
// RULE_01: Receive buffer high id byte (bits 15..8) is read-only, no reset value.
// RULE_02: Transmit buffer high id byte is readable and writable by software.
// RULE_03: Receive buffer low id byte (bits 7..0) is read-only, no reset value.
// RULE_04: Six buffers 0..5, each direction from its bit of the direction register.
// RULE_05: Buffer id registers and upper mask select reachable only in mode 1 or 2.
// RULE_06: Upper mask select holds four two-bit filter fields 15..12, reset to zero.
// RULE_07: Codes 00 mask 0, 01 mask 1, 10 filter 15, 11 no mask.
// RULE_08: Bit timing registers change only in configuration mode.
// RULE_09: Time quantum derives from the prescaler field of the first timing register.
// RULE_10: Two-bit jump width field in first timing register sets resync width in quanta.
// RULE_11: Transmit buffer low id byte is readable and writable too.
`timescale 1ns/10ps
module can_buffer_id_mask_select #(
    parameter int NUM_BUF = can_cfg_pkg::NUM_BUF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [NUM_BUF-1:0] rx_id_load,
    input wire logic [15:0] rx_id_value,
    output logic [NUM_BUF-1:0] buffer_tx_dir,
    output can_cfg_pkg::mask_src_t filter15_mask_choice,
    output can_cfg_pkg::mask_src_t filter14_mask_choice,
    output can_cfg_pkg::mask_src_t filter13_mask_choice,
    output can_cfg_pkg::mask_src_t filter12_mask_choice,
    output can_cfg_pkg::timing_cfg_t timing_cfg,
    output logic [2:0] resync_jump_width,
    output logic quantum_tick
);
    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic rst_meta_n;
    logic rst_sync_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    // One wait cycle: the request is decoded while waitrequest is high,
    // then waitrequest drops for exactly one cycle with readdata valid.
    logic next_waitrequest;
    logic [31:0] next_readdata;
    logic accept;
    logic wr_en;

    assign accept = (read || write) && waitrequest;
    assign wr_en = write && !waitrequest && byteenable[0];

    always_comb begin
        next_waitrequest = !accept;
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    logic [7:0] mode_ctrl;
    logic [7:0] buffer_direction_register;
    logic [7:0] filter_mask_choice_upper;
    logic [7:0] bit_timing_ctrl_first;
    logic [7:0] bit_timing_ctrl_second;
    logic [7:0] bit_timing_ctrl_third;
    logic [7:0] next_mode_ctrl;
    logic [7:0] next_dir;
    logic [7:0] next_mask;
    logic [7:0] next_t1;
    logic [7:0] next_t2;
    logic [7:0] next_t3;
    logic config_mode;
    logic [1:0] func_mode;
    logic id_window_open;

    assign config_mode = mode_ctrl[can_cfg_pkg::CFG_BIT];
    assign func_mode = mode_ctrl[can_cfg_pkg::FMODE_LSB +: 2];
    // Mode 3 is not defined, so only 1 and 2 open the window
    assign id_window_open = (func_mode != can_cfg_pkg::FMODE_LEGACY) && (func_mode <= can_cfg_pkg::FMODE_ENH_FIFO); // RULE_05

    always_comb begin
        next_mode_ctrl = mode_ctrl;
        next_dir = buffer_direction_register;
        next_mask = filter_mask_choice_upper;
        next_t1 = bit_timing_ctrl_first;
        next_t2 = bit_timing_ctrl_second;
        next_t3 = bit_timing_ctrl_third;
        if (wr_en) begin
            unique case (address)
                can_cfg_pkg::OFF_MODE_CTRL: begin
                    next_mode_ctrl = {5'h00, writedata[2:0]};
                end
                can_cfg_pkg::OFF_BUF_DIR: begin
                    next_dir = writedata[7:0] & 8'(((1 << NUM_BUF) - 1)); // RULE_04
                end
                can_cfg_pkg::OFF_MASK_CHOICE: begin
                    if (id_window_open) begin // RULE_05
                        next_mask = writedata[7:0]; // RULE_06
                    end
                end
                can_cfg_pkg::OFF_TIMING_FIRST: begin
                    if (config_mode) begin // RULE_08
                        next_t1 = writedata[7:0];
                    end
                end
                can_cfg_pkg::OFF_TIMING_SECOND: begin
                    if (config_mode) begin // RULE_08
                        next_t2 = writedata[7:0];
                    end
                end
                can_cfg_pkg::OFF_TIMING_THIRD: begin
                    if (config_mode) begin // RULE_08
                        next_t3 = writedata[7:0];
                    end
                end
                default: begin
                    next_mode_ctrl = mode_ctrl;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mode_ctrl <= can_cfg_pkg::MODE_CTRL_RST;
            buffer_direction_register <= can_cfg_pkg::BUF_DIR_RST;
            filter_mask_choice_upper <= can_cfg_pkg::MASK_CHOICE_RST; // RULE_06
            bit_timing_ctrl_first <= can_cfg_pkg::TIMING_RST;
            bit_timing_ctrl_second <= can_cfg_pkg::TIMING_RST;
            bit_timing_ctrl_third <= can_cfg_pkg::TIMING_RST;
            waitrequest <= 1'b1;
        end else if (ce) begin
            mode_ctrl <= next_mode_ctrl;
            buffer_direction_register <= next_dir;
            filter_mask_choice_upper <= next_mask;
            bit_timing_ctrl_first <= next_t1;
            bit_timing_ctrl_second <= next_t2;
            bit_timing_ctrl_third <= next_t3;
            waitrequest <= next_waitrequest;
        end
    end

    // ----------------------------------------
    // Buffer extended identifiers
    // ----------------------------------------
    // The id bytes carry no reset: their content is undefined until a
    // frame is received or software writes a transmit buffer.
    logic [7:0] id_high [NUM_BUF];
    logic [7:0] id_low [NUM_BUF];

    for (genvar n = 0; n < NUM_BUF; n++) begin : g_buf
        logic [7:0] next_high;
        logic [7:0] next_low;
        logic hit_high;
        logic hit_low;
        logic tx_dir;

        assign tx_dir = buffer_direction_register[n]; // RULE_04
        assign hit_high = address == 8'(can_cfg_pkg::OFF_BUF_BASE + n * can_cfg_pkg::BUF_STRIDE);
        assign hit_low = address == 8'(can_cfg_pkg::OFF_BUF_BASE + n * can_cfg_pkg::BUF_STRIDE
                                       + can_cfg_pkg::OFF_ID_LOW);

        always_comb begin
            next_high = id_high[n];
            next_low = id_low[n];
            if (!tx_dir && rx_id_load[n]) begin
                next_high = rx_id_value[15:8]; // RULE_01
                next_low = rx_id_value[7:0]; // RULE_03
            end
            if (wr_en && id_window_open && tx_dir && hit_high) begin
                next_high = writedata[7:0]; // RULE_02
            end
            if (wr_en && id_window_open && tx_dir && hit_low) begin
                next_low = writedata[7:0]; // RULE_11
            end
        end

        always_ff @(posedge clk) begin
            if (ce) begin
                id_high[n] <= next_high;
                id_low[n] <= next_low;
            end
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    logic [3:0] tq_count;

    always_comb begin
        next_readdata = can_cfg_pkg::READ_ZERO;
        if (accept && read) begin
            unique case (address)
                can_cfg_pkg::OFF_MODE_CTRL: next_readdata = {24'h000000, mode_ctrl};
                can_cfg_pkg::OFF_BUF_DIR: next_readdata = {24'h000000, buffer_direction_register};
                can_cfg_pkg::OFF_MASK_CHOICE: begin
                    if (id_window_open) begin // RULE_05
                        next_readdata = {24'h000000, filter_mask_choice_upper};
                    end
                end
                can_cfg_pkg::OFF_TIMING_FIRST: next_readdata = {24'h000000, bit_timing_ctrl_first};
                can_cfg_pkg::OFF_TIMING_SECOND: next_readdata = {24'h000000, bit_timing_ctrl_second};
                can_cfg_pkg::OFF_TIMING_THIRD: next_readdata = {24'h000000, bit_timing_ctrl_third};
                can_cfg_pkg::OFF_STATUS: next_readdata = {23'h000000, id_window_open, tq_count, 3'h0, config_mode};
                default: begin
                    for (int k = 0; k < NUM_BUF; k++) begin
                        if (id_window_open && address == 8'(can_cfg_pkg::OFF_BUF_BASE
                                                           + k * can_cfg_pkg::BUF_STRIDE)) begin
                            next_readdata = {24'h000000, id_high[k]}; // RULE_01
                        end
                        if (id_window_open && address == 8'(can_cfg_pkg::OFF_BUF_BASE
                                                           + k * can_cfg_pkg::BUF_STRIDE
                                                           + can_cfg_pkg::OFF_ID_LOW)) begin
                            next_readdata = {24'h000000, id_low[k]}; // RULE_03
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            readdata <= can_cfg_pkg::READ_ZERO;
        end else if (ce) begin
            readdata <= next_readdata;
        end
    end

    // ----------------------------------------
    // Time quantum generator
    // ----------------------------------------
    // Quantum lasts 2 * (prescaler + 1) clocks; halted in configuration
    // mode so a new prescaler starts from a clean quantum boundary.
    logic [can_cfg_pkg::PRESCALER_W:0] tq_div;
    logic [can_cfg_pkg::PRESCALER_W:0] next_tq_div;
    logic [3:0] next_tq_count;
    logic next_tick;

    always_comb begin
        next_tq_div = tq_div;
        next_tq_count = tq_count;
        next_tick = 1'b0;
        if (config_mode) begin
            next_tq_div = '0;
        end else if (tq_div == {bit_timing_ctrl_first[can_cfg_pkg::PRESCALER_W-1:0], 1'b1}) begin // RULE_09
            next_tq_div = '0;
            next_tick = 1'b1;
            next_tq_count = tq_count + 4'h1;
        end else begin
            next_tq_div = tq_div + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tq_div <= '0;
            tq_count <= 4'h0;
            quantum_tick <= 1'b0;
        end else if (ce) begin
            tq_div <= next_tq_div;
            tq_count <= next_tq_count;
            quantum_tick <= next_tick;
        end
    end

    // ----------------------------------------
    // Registered configuration outputs
    // ----------------------------------------
    can_cfg_pkg::timing_cfg_t next_timing;

    always_comb begin
        next_timing.jump_width = bit_timing_ctrl_first[can_cfg_pkg::JUMP_LSB +: 2]; // RULE_10
        next_timing.prescaler = bit_timing_ctrl_first[can_cfg_pkg::PRESCALER_W-1:0]; // RULE_09
        next_timing.second = bit_timing_ctrl_second;
        next_timing.third = bit_timing_ctrl_third;
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            timing_cfg <= '0;
            resync_jump_width <= 3'h1;
            buffer_tx_dir <= '0;
            filter15_mask_choice <= can_cfg_pkg::MASK_ACCEPT0;
            filter14_mask_choice <= can_cfg_pkg::MASK_ACCEPT0;
            filter13_mask_choice <= can_cfg_pkg::MASK_ACCEPT0;
            filter12_mask_choice <= can_cfg_pkg::MASK_ACCEPT0;
        end else if (ce) begin
            timing_cfg <= next_timing;
            resync_jump_width <= {1'b0, next_timing.jump_width} + 3'h1; // RULE_10
            buffer_tx_dir <= buffer_direction_register[NUM_BUF-1:0];
            filter15_mask_choice <= can_cfg_pkg::mask_src_t'(filter_mask_choice_upper[7:6]); // RULE_07
            filter14_mask_choice <= can_cfg_pkg::mask_src_t'(filter_mask_choice_upper[5:4]); // RULE_07
            filter13_mask_choice <= can_cfg_pkg::mask_src_t'(filter_mask_choice_upper[3:2]); // RULE_07
            filter12_mask_choice <= can_cfg_pkg::mask_src_t'(filter_mask_choice_upper[1:0]); // RULE_07
        end
    end
endmodule // can_buffer_id_mask_select

// ===== core/can_cfg_pkg.sv
// Register map, field layout and shared types of the buffer id / mask select / bit timing slice
package can_cfg_pkg;
    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] OFF_MODE_CTRL = 8'h00;
    localparam logic [7:0] OFF_BUF_DIR = 8'h04;
    localparam logic [7:0] OFF_MASK_CHOICE = 8'h08;
    localparam logic [7:0] OFF_TIMING_FIRST = 8'h0C;
    localparam logic [7:0] OFF_TIMING_SECOND = 8'h10;
    localparam logic [7:0] OFF_TIMING_THIRD = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_BUF_BASE = 8'h40;
    localparam logic [7:0] BUF_STRIDE = 8'h08;
    localparam logic [7:0] OFF_ID_LOW = 8'h04;
    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int CFG_BIT = 0;
    localparam int FMODE_LSB = 1;
    localparam int JUMP_LSB = 6;
    localparam int PRESCALER_W = 6;
    localparam int NUM_BUF = 6;
    localparam int NUM_FIL = 4;
    localparam logic [1:0] FMODE_LEGACY = 2'h0;
    localparam logic [1:0] FMODE_ENH_FIFO = 2'h2;
    localparam logic [7:0] MODE_CTRL_RST = 8'h01;
    localparam logic [7:0] BUF_DIR_RST = 8'h00;
    localparam logic [7:0] MASK_CHOICE_RST = 8'h00;
    localparam logic [7:0] TIMING_RST = 8'h00;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        MASK_ACCEPT0,
        MASK_ACCEPT1,
        MASK_FILTER15,
        MASK_NONE
    } mask_src_t;

    typedef struct packed {
        logic [1:0] jump_width;
        logic [PRESCALER_W-1:0] prescaler;
        logic [7:0] second;
        logic [7:0] third;
    } timing_cfg_t;
endpackage

// ===== verification/can_buffer_id_mask_select_chk.sv
// Concurrent checks on the register slice ports
`timescale 1ns/10ps
module can_buffer_id_mask_select_chk #(
    parameter int NUM_BUF = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic [NUM_BUF-1:0] buffer_tx_dir,
    input wire can_cfg_pkg::timing_cfg_t timing_cfg,
    input wire logic [2:0] resync_jump_width,
    input wire logic quantum_tick
);
    logic [7:0] gap;
    logic seen;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Gap is only trusted while the timing setup stays put
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap <= 8'h00;
            seen <= 1'b0;
        end else begin
            gap <= quantum_tick ? 8'h01 : ((gap == 8'hFF) ? gap : gap + 8'h01);
            seen <= quantum_tick | (seen & $stable(timing_cfg));
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    chk_wait_one: assert property ((read || write) && waitrequest && ce |=> !waitrequest)
        else $error("request not answered after one wait cycle");
    chk_wait_pulse: assert property (!waitrequest |=> waitrequest)
        else $error("answer held longer than one cycle");
    chk_wait_idle: assert property (!read && !write && waitrequest |=> waitrequest)
        else $error("answer without request");
    chk_rdata_idle: assert property (waitrequest |-> readdata == 32'h0000_0000)
        else $error("read data outside answer cycle");
    chk_rdata_upper: assert property (readdata[31:8] == 24'h00_0000)
        else $error("upper read data bits set");
    chk_dir_copy: assert property (!waitrequest && $past(read) && $past(address) == 8'h04
        |-> readdata[NUM_BUF-1:0] == buffer_tx_dir)
        else $error("direction output differs from register");
    chk_jump_width: assert property ($stable(timing_cfg) && timing_cfg == $past(timing_cfg, 2)
        |-> resync_jump_width == {1'b0, timing_cfg.jump_width} + 3'h1)
        else $error("jump width not field plus one");
    chk_tick_single: assert property (quantum_tick |=> !quantum_tick)
        else $error("quantum tick longer than one cycle");
    chk_tick_gap: assert property (quantum_tick && seen
        |-> gap == ({2'b00, timing_cfg.prescaler} + 8'h01) << 1)
        else $error("quantum period wrong");
endmodule // can_buffer_id_mask_select_chk

bind can_buffer_id_mask_select can_buffer_id_mask_select_chk #(.NUM_BUF(NUM_BUF)) chk_inst (
    .clk(clk), .rst_n(rst_n), .ce(ce), .address(address), .read(read), .write(write),
    .readdata(readdata), .waitrequest(waitrequest), .buffer_tx_dir(buffer_tx_dir),
    .timing_cfg(timing_cfg), .resync_jump_width(resync_jump_width), .quantum_tick(quantum_tick));

// ===== verification/can_buffer_id_mask_select_tb_top.sv
// Self-checking bench for the buffer id, mask select and bit timing slice
`timescale 1ns/10ps
module can_buffer_id_mask_select_tb_top;
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [7:0] d;
    } row_t;
    localparam logic [5:0] DIR = 6'h2A;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'hF;
    logic [31:0] writedata = 32'h0000_0000;
    logic [31:0] readdata;
    logic waitrequest;
    logic [5:0] rx_id_load;
    logic [15:0] rx_id_value;
    logic [5:0] buffer_tx_dir;
    can_cfg_pkg::mask_src_t f15, f14, f13, f12;
    can_cfg_pkg::timing_cfg_t timing_cfg;
    logic [2:0] resync_jump_width;
    logic quantum_tick;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    int g;
    logic [7:0] q;
    logic [7:0] ba;
    logic [7:0] tv [3] = '{8'h40, 8'hBF, 8'h05};
    row_t rows [22] = '{
        '{1'b0, 8'h00, 8'h01}, '{1'b0, 8'h08, 8'h00}, '{1'b1, 8'h08, 8'hFF}, '{1'b0, 8'h08, 8'h00},
        '{1'b0, 8'h10, 8'h00}, '{1'b1, 8'h0C, 8'hC3}, '{1'b0, 8'h0C, 8'hC3}, '{1'b1, 8'h10, 8'h5A},
        '{1'b0, 8'h10, 8'h5A}, '{1'b1, 8'h14, 8'hA5}, '{1'b0, 8'h14, 8'hA5}, '{1'b1, 8'h04, 8'h2A},
        '{1'b0, 8'h04, 8'h2A}, '{1'b1, 8'h30, 8'h77}, '{1'b0, 8'h30, 8'h00}, '{1'b1, 8'h00, 8'h02},
        '{1'b0, 8'h00, 8'h02}, '{1'b1, 8'h0C, 8'h00}, '{1'b0, 8'h0C, 8'hC3}, '{1'b0, 8'h08, 8'h00},
        '{1'b1, 8'h08, 8'hE4}, '{1'b0, 8'h08, 8'hE4}};

    can_buffer_id_mask_select can_buffer_id_mask_select_inst (
        .clk(clk), .rst_n(rst_n), .ce(ce), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .rx_id_load(rx_id_load), .rx_id_value(rx_id_value), .buffer_tx_dir(buffer_tx_dir),
        .filter15_mask_choice(f15), .filter14_mask_choice(f14), .filter13_mask_choice(f13),
        .filter12_mask_choice(f12), .timing_cfg(timing_cfg), .resync_jump_width(resync_jump_width),
        .quantum_tick(quantum_tick));
    can_engine_model can_engine_model_inst (.clk(clk), .rx_id_load(rx_id_load), .rx_id_value(rx_id_value));

    always #4 clk = ~clk;

    task automatic wrap_up;
        if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Hang guard: the whole sequence needs well under this many cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            wrap_up;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        address <= a;
        write <= w;
        read <= !w;
        writedata <= {24'h00_0000, d};
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata[7:0];
        write <= 1'b0;
        read <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        check({24'h00_0000, q}, {24'h00_0000, exp});
    endtask

    task automatic tick_gap(output int n);
        n = 0;
        do @(posedge clk); while (quantum_tick !== 1'b1);
        do begin
            @(posedge clk);
            n++;
        end while (quantum_tick !== 1'b1);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        check({14'h0000, waitrequest, resync_jump_width, buffer_tx_dir, f15, f14, f13, f12}, 32'h0002_4000);
        check(readdata, 32'h0000_0000);
        check({8'h00, timing_cfg}, 32'h0000_0000);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 22; i++) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            else rd_chk(rows[i].a, rows[i].d);
        end
        check({24'h00_0000, f15, f14, f13, f12}, {24'h00_0000, can_cfg_pkg::MASK_NONE,
            can_cfg_pkg::MASK_FILTER15, can_cfg_pkg::MASK_ACCEPT1, can_cfg_pkg::MASK_ACCEPT0});
        check({26'h000_0000, buffer_tx_dir}, {26'h000_0000, DIR});
        // Receive buffers refuse writes, transmit buffers ignore engine loads
        for (int n = 0; n < 6; n++) begin
            ba = 8'h40 + 8'(n * 8);
            if (DIR[n]) begin
                wr(ba, 8'h90 + 8'(n));
                wr(ba + 8'h04, 8'h60 + 8'(n));
                can_engine_model_inst.load(3'(n), 16'hFFFF);
            end else begin
                can_engine_model_inst.load(3'(n), {8'hB0 + 8'(n), 8'hD0 + 8'(n)});
                wr(ba, 8'h11);
                wr(ba + 8'h04, 8'h22);
            end
        end
        for (int n = 0; n < 6; n++) begin
            ba = 8'h40 + 8'(n * 8);
            rd_chk(ba, DIR[n] ? 8'h90 + 8'(n) : 8'hB0 + 8'(n));
            rd_chk(ba + 8'h04, DIR[n] ? 8'h60 + 8'(n) : 8'hD0 + 8'(n));
        end
        // A write without byte lane 0 is answered but must not land
        byteenable <= 4'hE;
        wr(8'h08, 8'h00);
        byteenable <= 4'hF;
        rd_chk(8'h08, 8'hE4);
        wr(8'h00, 8'h04);
        rd_chk(8'h48, 8'h91);
        wr(8'h00, 8'h06);
        wr(8'h48, 8'h33);
        rd_chk(8'h48, 8'h00);
        rd_chk(8'h08, 8'h00);
        check({8'h00, timing_cfg}, 32'h00C3_5AA5);
        tick_gap(g);
        check(g, 32'h0000_0008);
        check({29'h0000_0000, resync_jump_width}, 32'h0000_0004);
        for (int i = 0; i < 3; i++) begin
            wr(8'h00, 8'h01);
            wr(8'h0C, tv[i]);
            wr(8'h00, 8'h02);
            tick_gap(g);
            check(g, {24'h00_0000, {1'b0, tv[i][5:0]} + 7'h01, 1'b0});
            check({29'h0000_0000, resync_jump_width}, {29'h0000_0000, {1'b0, tv[i][7:6]} + 3'h1});
        end
        rd_chk(8'h48, 8'h91);
        // Mid-run reset: registers fall back to their reset values
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rd_chk(8'h00, 8'h01);
        rd_chk(8'h0C, 8'h00);
        wr(8'h00, 8'h02);
        rd_chk(8'h08, 8'h00);
        check({24'h00_0000, f15, f14, f13, f12}, 32'h0000_0000);
        wrap_up;
    end
endmodule // can_buffer_id_mask_select_tb_top

// ===== verification/can_engine_model.sv
// Behavioural model of the receive engine that loads received ids into buffers
`timescale 1ns/10ps
module can_engine_model #(
    parameter int NUM_BUF = 6
) (
    input wire logic clk,
    output logic [NUM_BUF-1:0] rx_id_load,
    output logic [15:0] rx_id_value
);
    initial begin
        rx_id_load = '0;
        rx_id_value = 16'h0000;
    end

    task automatic load(input logic [2:0] n, input logic [15:0] v);
        @(posedge clk);
        rx_id_load <= NUM_BUF'(1) << n;
        rx_id_value <= v;
        @(posedge clk);
        rx_id_load <= '0;
        // Stale id must not look valid once the pulse is gone
        rx_id_value <= ~v;
    endtask
endmodule // can_engine_model
